// ---- shared/spi_port_regs.svh ----
// register map, field positions, reset values and counts of the serial port
// Operation
// - excess flag bit 11 high while receive count exceeds threshold
// - receive fill count 0..4 reported in status bits 10:8
// - overflow bit 7 set on byte arriving into full receive fifo
// - status read clears event flags; fill counts keep tracking
// - direction clear and threshold bytes received sets bit 6
// - direction set and threshold bytes transmitted sets bit 5
// - transfer starting with empty transmit fifo sets underflow bit 4
// - transmit fill count 0..4 reported in status bits 3:1
// - summary bit 0 set on any port event, cleared by status read
// - status is 32-bit read-only, resets zero, bits 15:12 read zero
// - 8-bit read-only receive data register, reset zero
// - 8-bit write-only transmit data register, reset zero
// - 8-bit write-only baud divider, resets to 0x1b
// - 16-bit read-write control register, resets to zero
// - master serial clock is core clock over 2*(1+divider)
// - two-bit threshold selects one to four bytes
// - bytes shift eight bits, msb first, both lines together
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

`define ADDR_PORT_STATUS   32'hffff0a00
`define ADDR_RX_DATA       32'hffff0a04
`define ADDR_TX_DATA       32'hffff0a08
`define ADDR_BAUD_DIVIDER  32'hffff0a0c
`define ADDR_PORT_CONTROL  32'hffff0a10
`define ADDR_IRQ_MASK      32'hffff0a14
`define ADDR_IRQ_EVENT     32'hffff0a18

`define RST_PORT_STATUS    32'h00000000
`define RST_DATA           8'h00
`define RST_BAUD_DIVIDER   8'h1b
`define RST_PORT_CONTROL   16'h0000
`define RST_IRQ            4'h0

`define ST_EXCESS_BIT      11
`define ST_RX_LEVEL_LSB    8
`define ST_OVERFLOW_BIT    7
`define ST_RX_IRQ_BIT      6
`define ST_TX_IRQ_BIT      5
`define ST_UNDERFLOW_BIT   4
`define ST_TX_LEVEL_LSB    1
`define ST_SUMMARY_BIT     0

`define EV_OVERFLOW        0
`define EV_RX_IRQ          1
`define EV_TX_IRQ          2
`define EV_UNDERFLOW       3

`define FIFO_DEPTH         4
`define BITS_PER_BYTE      8

`endif

// ---- shared/spi_port_pkg.sv ----
// types of the serial port block
package spi_port_pkg;

   // port_control_reg layout, bit 15 first
   typedef struct packed {
      logic [1:0] irq_threshold_sel;
      logic       tx_flush_en;
      logic       rx_flush_en;
      logic       cont_en;
      logic       loopback_en;
      logic       miso_drive_en;
      logic [1:0] rsv_hi;
      logic       transfer_direction_sel;
      logic [3:0] rsv_lo;
      logic       master_en;
      logic       port_en;
   } ctrl_t;

   // serial pin outputs with their enables
   typedef struct packed {
      logic sclk;
      logic sclk_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
      logic ss_n;
      logic ss_oe;
   } pins_out_t;

   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_xfer = 2'b10
   } mstate_t;

endpackage : spi_port_pkg

// ---- hw/spi_status_and_register_port.sv ----
// serial peripheral port: register file, status, fifos and byte shifter
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "spi_port_regs.svh"

module spi_status_and_register_port
   import spi_port_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_ce,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   output logic             o_irq,
   input  wire logic        i_sclk,
   input  wire logic        i_mosi,
   input  wire logic        i_miso,
   input  wire logic        i_ss_n,
   output pins_out_t        o_pins
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   // registers
   ctrl_t           ctrl_r;
   logic [7:0]      div_r;
   logic [3:0]      mask_r;
   logic [3:0]      event_r;
   logic [3:0]      event_nxt;
   logic            ovf_r;
   logic            rxirq_r;
   logic            txirq_r;
   logic            uf_r;
   logic            sum_r;
   logic [7:0]      tx_last_r;

   // fifos
   logic [7:0]      rx_mem_r [DEPTH];
   logic [7:0]      tx_mem_r [DEPTH];
   logic [PW-1:0]   rx_wp_r;
   logic [PW-1:0]   rx_rp_r;
   logic [PW-1:0]   tx_wp_r;
   logic [PW-1:0]   tx_rp_r;
   logic [CW-1:0]   rx_cnt_r;
   logic [CW-1:0]   tx_cnt_r;
   logic [CW-1:0]   rx_cnt_nxt;
   logic [CW-1:0]   tx_cnt_nxt;

   // shifter
   mstate_t         state_r;
   logic [7:0]      div_cnt_r;
   logic            sclk_r;
   logic            sclk_in_r;
   logic            ss_in_r;
   logic [7:0]      sh_out_r;
   logic [7:0]      sh_in_r;
   logic [2:0]      bit_cnt_r;
   logic            reload_r;
   logic [2:0]      sent_cnt_r;

   // register decode
   wire sel_sta  = (i_addr == `ADDR_PORT_STATUS);
   wire sel_rx   = (i_addr == `ADDR_RX_DATA);
   wire sel_tx   = (i_addr == `ADDR_TX_DATA);
   wire sel_div  = (i_addr == `ADDR_BAUD_DIVIDER);
   wire sel_ctl  = (i_addr == `ADDR_PORT_CONTROL);
   wire sel_mask = (i_addr == `ADDR_IRQ_MASK);
   wire sel_ev   = (i_addr == `ADDR_IRQ_EVENT);

   wire sta_rd   = i_rd & sel_sta;
   wire rx_rd    = i_rd & sel_rx;
   wire tx_wr    = i_wr & sel_tx;

   // threshold one to four bytes
   wire [CW-1:0] thr = CW'({1'b0, ctrl_r.irq_threshold_sel}) + CW'(1);

   // shifter control
   wire is_master = ctrl_r.master_en;
   wire enabled   = ctrl_r.port_en;
   wire tx_flush  = ctrl_r.tx_flush_en;
   wire rx_flush  = ctrl_r.rx_flush_en;
   wire dir_tx    = ctrl_r.transfer_direction_sel;
   wire tx_avail  = (tx_cnt_r != '0);
   wire m_idle    = (state_r == st_idle);

   // master starts on queued data or, flushing rx in rx mode, on rx read
   wire m_start   = enabled & is_master & m_idle &
                    ((tx_avail & ~tx_flush) | (rx_rd & rx_flush & ~dir_tx));
   wire s_start   = enabled & ~is_master & ss_in_r & ~i_ss_n;
   wire start     = m_start | s_start;

   wire tick      = (state_r == st_xfer) & (div_cnt_r == div_r);
   wire m_rise    = tick & ~sclk_r;
   wire m_fall    = tick & sclk_r;
   wire s_act     = enabled & ~is_master & ~i_ss_n;
   wire s_rise    = s_act & i_sclk & ~sclk_in_r;
   wire s_fall    = s_act & ~i_sclk & sclk_in_r;
   wire rise      = is_master ? m_rise : s_rise;
   wire fall      = is_master ? m_fall : s_fall;

   // byte load happens at start and on the fall after a finished byte, except where the master frame ends
   wire m_more    = ctrl_r.cont_en & tx_avail & ~tx_flush;
   wire m_end     = is_master & fall & reload_r & ~m_more;
   wire load      = start | (fall & reload_r & ~m_end);
   wire load_pop  = load & tx_avail & ~tx_flush;
   wire load_uf   = load & ~tx_avail;

   wire din       = ctrl_r.loopback_en ? sh_out_r[7] :
                    (is_master ? i_miso : i_mosi);
   wire byte_done = rise & (bit_cnt_r == 3'd7);
   wire [7:0] rx_byte = {sh_in_r[6:0], din};

   // fifo moves
   wire rx_push_req = byte_done & ~rx_flush;
   wire rx_full     = (rx_cnt_r == FULL);
   wire rx_pop      = rx_rd & (rx_cnt_r != '0) & ~rx_flush;
   wire rx_push     = rx_push_req & (~rx_full | rx_pop);
   wire tx_full     = (tx_cnt_r == FULL);
   wire tx_push     = tx_wr & ~tx_flush & (~tx_full | load_pop);

   // event sources
   wire ovf_set   = rx_push_req & rx_full & ~rx_pop;
   wire rxirq_set = rx_push & ~dir_tx & (rx_cnt_nxt >= thr);
   wire [2:0] sent_nxt = sent_cnt_r + 3'd1;
   wire txirq_set = byte_done & dir_tx &
                    (CW'(sent_nxt) >= thr);
   wire uf_set    = load_uf & ~tx_flush;
   wire any_set   = ovf_set | rxirq_set | txirq_set | uf_set;

   // status word
   wire excess = (rx_cnt_r > thr);
   wire [31:0] status_word = {
      16'h0000,
      4'h0,
      excess,
      rx_cnt_r,
      ovf_r,
      rxirq_r,
      txirq_r,
      uf_r,
      tx_cnt_r,
      sum_r
   };

   wire [3:0] ev_src = {uf_set, txirq_set, rxirq_set, ovf_set};
   wire [PW-1:0] rx_wp_nxt = rx_wp_r + PW'(1);
   wire [PW-1:0] rx_rp_nxt = rx_rp_r + PW'(1);
   wire [PW-1:0] tx_wp_nxt = tx_wp_r + PW'(1);
   wire [PW-1:0] tx_rp_nxt = tx_rp_r + PW'(1);
   wire [7:0] tx_head = tx_mem_r[tx_rp_r];
   wire [7:0] rx_head = rx_mem_r[rx_rp_r];

   // write-only registers and unmapped addresses read zero
   wire [31:0] rd_mux =
      sel_sta  ? status_word :
      sel_rx   ? {24'h000000, rx_head} :
      sel_ctl  ? {16'h0000, ctrl_r} :
      sel_mask ? {28'h0000000, mask_r} :
      sel_ev   ? {28'h0000000, event_r} :
      32'h00000000;

   // set wins over write-one-to-clear
   assign event_nxt = (event_r & ~(i_wr & sel_ev ? i_wdata[3:0] : 4'h0))
                      | ev_src;

   assign rx_cnt_nxt = rx_flush ? '0 :
                       rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
   assign tx_cnt_nxt = tx_flush ? '0 :
                       tx_cnt_r + CW'(tx_push) - CW'(load_pop);

   assign o_irq = |(event_r & mask_r);

   // pins; miso without drive enable acts as open drain
   assign o_pins.sclk    = sclk_r;
   assign o_pins.sclk_oe = enabled & is_master;
   assign o_pins.mosi    = sh_out_r[7];
   assign o_pins.mosi_oe = enabled & is_master;
   assign o_pins.miso    = sh_out_r[7];
   assign o_pins.miso_oe = s_act & (ctrl_r.miso_drive_en | ~sh_out_r[7]);
   assign o_pins.ss_n    = ~(is_master & ~m_idle);
   assign o_pins.ss_oe   = enabled & is_master;

   // bus registers
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ctrl_r  <= ctrl_t'(`RST_PORT_CONTROL);
         div_r   <= `RST_BAUD_DIVIDER;
         mask_r  <= `RST_IRQ;
         event_r <= `RST_IRQ;
         o_rdata <= `RST_PORT_STATUS;
      end else if (i_ce) begin
         if (i_wr & sel_ctl) begin
            ctrl_r <= ctrl_t'(i_wdata[15:0]);
         end
         if (i_wr & sel_div) begin
            div_r <= i_wdata[7:0];
         end
         if (i_wr & sel_mask) begin
            mask_r <= i_wdata[3:0];
         end
         event_r <= event_nxt;
         if (i_rd) begin
            o_rdata <= rd_mux;
         end
      end
   end

   // clear-on-read flags; a set in the read cycle survives
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ovf_r   <= 1'b0;
         rxirq_r <= 1'b0;
         txirq_r <= 1'b0;
         uf_r    <= 1'b0;
         sum_r   <= 1'b0;
      end else if (i_ce) begin
         ovf_r   <= ovf_set   | (ovf_r   & ~sta_rd);
         rxirq_r <= rxirq_set | (rxirq_r & ~sta_rd);
         txirq_r <= txirq_set | (txirq_r & ~sta_rd);
         uf_r    <= uf_set    | (uf_r    & ~sta_rd);
         sum_r   <= any_set   | (sum_r   & ~sta_rd);
      end
   end

   // receive fifo
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rx_wp_r  <= '0;
         rx_rp_r  <= '0;
         rx_cnt_r <= '0;
      end else if (i_ce) begin
         if (rx_flush) begin
            rx_wp_r <= '0;
            rx_rp_r <= '0;
         end else begin
            if (rx_push) begin
               rx_wp_r <= rx_wp_nxt;
            end
            if (rx_pop) begin
               rx_rp_r <= rx_rp_nxt;
            end
         end
         rx_cnt_r <= rx_cnt_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            rx_mem_r[i] <= `RST_DATA;
         end
      end else if (i_ce && rx_push) begin
         rx_mem_r[rx_wp_r] <= rx_byte;
      end
   end

   // transmit fifo; writes ignored while flushing, or while full unless load_pop takes a byte in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         tx_wp_r  <= '0;
         tx_rp_r  <= '0;
         tx_cnt_r <= '0;
      end else if (i_ce) begin
         if (tx_flush) begin
            tx_wp_r <= '0;
            tx_rp_r <= '0;
         end else begin
            if (tx_push) begin
               tx_wp_r <= tx_wp_nxt;
            end
            if (load_pop) begin
               tx_rp_r <= tx_rp_nxt;
            end
         end
         tx_cnt_r <= tx_cnt_nxt;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            tx_mem_r[i] <= `RST_DATA;
         end
      end else if (i_ce && tx_push) begin
         tx_mem_r[tx_wp_r] <= i_wdata[7:0];
      end
   end

   // master clock generator and frame state
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state_r   <= st_idle;
         div_cnt_r <= 8'h00;
         sclk_r    <= 1'b0;
      end else if (i_ce) begin
         case (state_r)
            st_idle: begin
               div_cnt_r <= 8'h00;
               sclk_r    <= 1'b0;
               if (m_start) begin
                  state_r <= st_xfer;
               end
            end
            st_xfer: begin
               // half period of div+1 core clocks
               if (tick) begin
                  div_cnt_r <= 8'h00;
                  sclk_r    <= ~sclk_r;
               end else begin
                  div_cnt_r <= div_cnt_r + 8'h01;
               end
               if (m_end | ~enabled | ~is_master) begin
                  state_r <= st_idle;
               end
            end
            default: begin
               state_r <= st_idle;
            end
         endcase
      end
   end

   // byte shifter: sample on rising edge, shift on falling edge
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         sclk_in_r  <= 1'b0;
         ss_in_r    <= 1'b1;
         sh_out_r   <= `RST_DATA;
         sh_in_r    <= `RST_DATA;
         bit_cnt_r  <= 3'd0;
         reload_r   <= 1'b0;
         sent_cnt_r <= 3'd0;
         tx_last_r  <= `RST_DATA;
      end else if (i_ce) begin
         sclk_in_r <= i_sclk;
         ss_in_r   <= i_ss_n;
         if (start) begin
            bit_cnt_r <= 3'd0;
            reload_r  <= 1'b0;
         end
         if (load) begin
            reload_r <= 1'b0;
            // an empty fifo sends zeros
            sh_out_r <= load_pop ? tx_head : 8'h00;
            if (load_pop) begin
               tx_last_r <= tx_head;
            end
         end else if (fall & ~reload_r) begin
            sh_out_r <= {sh_out_r[6:0], 1'b0};
         end
         if (rise) begin
            sh_in_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'd1;
         end
         if (byte_done) begin
            reload_r <= 1'b1;
         end
         if (tx_flush | ~dir_tx) begin
            sent_cnt_r <= 3'd0;
         end else if (byte_done) begin
            sent_cnt_r <= txirq_set ? 3'd0 : sent_nxt;
         end
      end
   end

endmodule : spi_status_and_register_port

// ---- verif/spi_port_monitor.sv ----
// assertions on register reads and master pins of the serial port
`timescale 1ns/1ps
`include "spi_port_regs.svh"

module spi_port_monitor
   import spi_port_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   input  wire logic        i_ce,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [31:0] o_rdata,
   input  wire pins_out_t   o_pins
);
   logic [7:0]  div_r;
   logic [15:0] ctrl_r;
   logic        sclk_q_r;
   logic        armed_r;
   logic [8:0]  half_r;
   logic [7:0]  rises_r;
   wire         tog = o_pins.sclk != sclk_q_r;
   wire         rd_ok = i_ce && i_rd;
   wire         st_rd = rd_ok && i_addr == `ADDR_PORT_STATUS;
   wire         rx_rd = rd_ok && i_addr == `ADDR_RX_DATA;
   wire         ct_rd = rd_ok && i_addr == `ADDR_PORT_CONTROL;
   wire         wo_rd = rd_ok && (i_addr == `ADDR_TX_DATA ||
                                  i_addr == `ADDR_BAUD_DIVIDER);
   wire [2:0]   thr = {1'b0, ctrl_r[15:14]} + 3'h1;

   // shadow of divider and control, half-period and rise counters
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         div_r <= `RST_BAUD_DIVIDER;
         ctrl_r <= `RST_PORT_CONTROL;
         sclk_q_r <= 1'b0;
         armed_r <= 1'b0;
         half_r <= 9'h0;
         rises_r <= 8'h0;
      end else if (i_ce) begin
         if (i_wr && i_addr == `ADDR_BAUD_DIVIDER) div_r <= i_wdata[7:0];
         if (i_wr && i_addr == `ADDR_PORT_CONTROL) ctrl_r <= i_wdata[15:0];
         sclk_q_r <= o_pins.sclk;
         half_r <= tog ? 9'h0 : half_r + 9'h1;
         armed_r <= !o_pins.ss_n && (armed_r || tog);
         rises_r <= o_pins.ss_n ? 8'h0 : rises_r + 8'(tog && o_pins.sclk);
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   property p_rsvd; st_rd |=> o_rdata[31:12] == 20'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("status high bits set");
   property p_rx_lvl; st_rd |=> o_rdata[10:8] <= DEPTH; endproperty
   a_rx_lvl: assert property (p_rx_lvl) else $error("rx level high");
   property p_tx_lvl; st_rd |=> o_rdata[3:1] <= DEPTH; endproperty
   a_tx_lvl: assert property (p_tx_lvl) else $error("tx level high");
   property p_excess; st_rd |=> o_rdata[11] == (o_rdata[10:8] > thr);
   endproperty
   a_excess: assert property (p_excess) else $error("excess wrong");
   property p_sum; st_rd |=> o_rdata[7:4] == 4'h0 || o_rdata[0]; endproperty
   a_sum: assert property (p_sum) else $error("summary missing");
   property p_wo; wo_rd |=> o_rdata == 32'h0; endproperty
   a_wo: assert property (p_wo) else $error("write-only reads back");
   property p_rx_w; rx_rd |=> o_rdata[31:8] == 24'h0; endproperty
   a_rx_w: assert property (p_rx_w) else $error("rx data too wide");
   property p_ctrl; ct_rd |=> o_rdata == {16'h0, ctrl_r}; endproperty
   a_ctrl: assert property (p_ctrl) else $error("control readback");
   property p_half; tog && armed_r && !o_pins.ss_n |-> half_r == div_r;
   endproperty
   a_half: assert property (p_half) else $error("sclk half period");
   property p_bytes; $rose(o_pins.ss_n) |-> rises_r[2:0] == 3'h0 &&
      rises_r != 8'h0; endproperty
   a_bytes: assert property (p_bytes) else $error("partial byte");
endmodule : spi_port_monitor

// ---- verif/spi_slave_model.sv ----
// behavioural serial slave that answers the port's master frames
`timescale 1ns/1ps

module spi_slave_model (
   input  wire logic       i_sclk,
   input  wire logic       i_mosi,
   input  wire logic       i_ss_n,
   input  wire logic [7:0] i_reply,
   output logic            o_miso,
   output logic [7:0]      o_got
);
   logic [7:0] sh_r = 8'h00;
   logic [7:0] in_r = 8'h00;
   logic [2:0] n_r = 3'h0;
   logic       last_r = 1'b0;

   initial o_got = 8'h00;
   // a released line shows the inverse of its last bit
   assign o_miso = i_ss_n ? ~last_r : sh_r[7];
   always @(negedge i_ss_n) begin
      sh_r = i_reply;
      n_r = 3'h0;
   end
   always @(posedge i_ss_n) last_r = sh_r[7];
   always @(posedge i_sclk) begin
      if (!i_ss_n) begin
         in_r = {in_r[6:0], i_mosi};
         n_r = n_r + 3'h1;
         if (n_r == 3'h0) o_got = in_r;
      end
   end
   always @(negedge i_sclk) begin
      if (!i_ss_n) sh_r = n_r == 3'h0 ? i_reply : {sh_r[6:0], 1'b0};
   end
endmodule : spi_slave_model

// ---- verif/spi_status_and_register_port_test.sv ----
// self-checking bench of the serial port registers and status
`timescale 1ns/1ps
`include "spi_port_regs.svh"

module spi_status_and_register_port_test
   import spi_port_pkg::*;
;
   logic        i_clk_sys = 1'b0;
   logic        i_reset = 1'b1;
   logic [31:0] i_addr = 32'h0;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic        o_irq;
   logic        miso;
   logic [7:0]  got;
   logic        s_sclk = 1'b0;
   logic        s_mosi = 1'b0;
   logic        s_ss_n = 1'b1;
   pins_out_t   o_pins;
   int          fail_count = 0;
   int          total_checks = 0;
   int          cyc = 0;

   always #5 i_clk_sys = ~i_clk_sys;

   spi_status_and_register_port #(.DEPTH(4)) i_spi_status_and_register_port (
      .i_clk_sys, .i_reset, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .o_irq, .i_sclk(s_sclk), .i_mosi(s_mosi), .i_miso(miso),
      .i_ss_n(s_ss_n), .o_pins);

   // the slave answers each byte with the inverse of the previous one
   spi_slave_model i_spi_slave_model (.i_sclk(o_pins.sclk),
      .i_mosi(o_pins.mosi), .i_ss_n(o_pins.ss_n), .i_reply(~got),
      .o_miso(miso), .o_got(got));

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         test_done;
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 v = o_rdata;
      @(posedge i_clk_sys);
   endtask : rd

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e);
   endtask : rdc

   // oldest byte in the top bits
   task automatic drain(input logic [31:0] b);
      for (int k = 3; k >= 0; k--) rdc(`ADDR_RX_DATA, {24'h0, b[8*k +: 8]});
   endtask : drain

   task automatic irq_is(input logic e);
      #1;
      chk({31'h0, o_irq}, {31'h0, e});
      @(posedge i_clk_sys);
   endtask : irq_is

   task automatic wait_irq;
      do begin
         @(posedge i_clk_sys);
         #1;
      end while (o_irq !== 1'b1);
      @(posedge i_clk_sys);
   endtask : wait_irq

   task automatic wait_idle;
      int q;
      q = 0;
      while (q < 64) begin
         @(posedge i_clk_sys);
         #1;
         q = o_pins.ss_n === 1'b1 ? q + 1 : 0;
      end
      @(posedge i_clk_sys);
   endtask : wait_idle

   // external master sends one byte in mode 0; miso taken before each rise
   task automatic sbyte(input logic [7:0] d, output logic [7:0] q);
      s_ss_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         s_mosi <= d[i];
         repeat (2) @(posedge i_clk_sys);
         #1 q[i] = o_pins.miso;
         if (i == 7) chk({24'h0, o_pins}, 32'h2e);
         @(posedge i_clk_sys);
         s_sclk <= 1'b1;
         repeat (2) @(posedge i_clk_sys);
         s_sclk <= 1'b0;
      end
      repeat (2) @(posedge i_clk_sys);
      s_ss_n <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
   endtask : sbyte

   initial begin
      logic [31:0] ra [6];
      logic [31:0] v;
      logic [7:0]  sq;
      ra = '{`ADDR_PORT_STATUS, `ADDR_RX_DATA, `ADDR_TX_DATA,
             `ADDR_BAUD_DIVIDER, `ADDR_PORT_CONTROL, 32'hffff0a1c};
      repeat (16) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      @(posedge i_clk_sys);
      foreach (ra[k]) rdc(ra[k], 32'h0);
      wr(`ADDR_IRQ_MASK, 32'hf);
      wr(`ADDR_PORT_CONTROL, 32'h1003);
      rd(`ADDR_RX_DATA, v);
      wait_irq;
      rdc(`ADDR_PORT_STATUS, 32'h11);
      wait_idle;
      rdc(`ADDR_PORT_STATUS, 32'h0);
      wr(`ADDR_IRQ_EVENT, 32'hf);
      irq_is(1'b0);
      wr(`ADDR_BAUD_DIVIDER, 32'h2);
      wr(`ADDR_PORT_CONTROL, 32'hc840);
      for (int k = 1; k < 6; k++) wr(`ADDR_TX_DATA, 32'h11 * k);
      rdc(`ADDR_PORT_STATUS, 32'h8);
      rdc(`ADDR_PORT_CONTROL, 32'hc840);
      wr(`ADDR_PORT_CONTROL, 32'hc843);
      wait_irq;
      wait_idle;
      rdc(`ADDR_PORT_STATUS, 32'h421);
      rdc(`ADDR_PORT_STATUS, 32'h400);
      chk({24'h0, got}, 32'h44);
      drain(32'hffeeddcc);
      rdc(`ADDR_IRQ_EVENT, 32'h4);
      wr(`ADDR_IRQ_MASK, 32'h0);
      irq_is(1'b0);
      wr(`ADDR_IRQ_MASK, 32'hf);
      irq_is(1'b1);
      wr(`ADDR_IRQ_EVENT, 32'hf);
      irq_is(1'b0);
      wr(`ADDR_PORT_CONTROL, 32'h0003);
      for (int k = 1; k < 5; k++) wr(`ADDR_TX_DATA, 32'ha0 + k);
      wait_idle;
      wr(`ADDR_TX_DATA, 32'ha5);
      wait_idle;
      rdc(`ADDR_PORT_STATUS, 32'hcc1);
      rdc(`ADDR_PORT_STATUS, 32'hc00);
      drain(32'hbb5e5d5c);
      rdc(`ADDR_PORT_STATUS, 32'h0);
      wr(`ADDR_PORT_CONTROL, 32'h0201);
      wr(`ADDR_TX_DATA, 32'h96);
      sbyte(8'h3c, sq);
      chk({24'h0, sq}, 32'h96);
      rdc(`ADDR_RX_DATA, 32'h3c);
      test_done;
   end
endmodule : spi_status_and_register_port_test

bind spi_status_and_register_port spi_port_monitor #(.DEPTH(DEPTH))
   i_spi_port_monitor (.i_clk_sys, .i_reset, .i_ce, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .o_pins);
